/* src/cpfd_defs.svh */
`ifndef CPFD_DEFS_SVH
`define CPFD_DEFS_SVH

// APB byte offsets and the commit bit of the control register.
`define CPFD_OFS_CTRL         12'h000
`define CPFD_OFS_STATUS       12'h004
`define CPFD_OFS_COUNT        12'h008
`define CPFD_CTRL_COMMIT_BIT  8
// Reset value of the device select field (value is arbitrary).
`define CPFD_DEV_ADDR_RST     7'h2A

// Location map boundaries.
`define CPFD_LOC_COEF_LAST    12'h3FF
`define CPFD_LOC_PROG_LAST    12'h7FF
`define CPFD_LOC_IFACE_LAST   12'h807
`define CPFD_LOC_SLDATA_FIRST 12'h810
`define CPFD_LOC_SLADDR_FIRST 12'h815
`define CPFD_LOC_CAPT_FIRST   12'h81A
`define CPFD_LOC_CAPT_LAST    12'h81B
`define CPFD_LOC_BYTE1_FIRST  12'h81E
`define CPFD_LOC_BYTE1_LAST   12'h81F

// Data bytes per word.
`define CPFD_LEN_COEF         3'h4
`define CPFD_LEN_PROG         3'h5
`define CPFD_LEN_SLDATA       3'h5
`define CPFD_LEN_CAPT_WR      3'h2
`define CPFD_LEN_CAPT_RD      3'h3
`define CPFD_LEN_BYTE1        3'h1
`define CPFD_LEN_REG          3'h2

// Significant bits per word.
`define CPFD_BITS_COEF        6'h1C
`define CPFD_BITS_PROG        6'h28
`define CPFD_BITS_SLADDR      6'h0A
`define CPFD_BITS_CAPT_WR     6'h0D
`define CPFD_BITS_CAPT_RD     6'h18

// Deferred slots.
`define CPFD_SLOT_COUNT       3'h5
`define CPFD_SLOT_LAST        3'h4
`endif

/* src/cpfd_pkg.sv */
package cpfd_pkg;
  // Decoder states.
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA, ST_SKIP} cpfd_state_t;
  // Location regions; the interface region shares the coefficient byte layout, the others each have their own.
  typedef enum logic [2:0] {RG_COEF, RG_PROG, RG_IFACE, RG_SLDATA, RG_SLADDR, RG_CAPT, RG_BYTE1, RG_REG} cpfd_region_t;
endpackage

/* src/cpfd_link_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module cpfd_link_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_spi_clk,
  input  wire logic i_spi_frame_latch,
  input  wire logic i_spi_mosi,
  output logic      o_sclk_rise,
  output logic      o_sclk_fall,
  output logic      o_frame_start,
  output logic      o_frame_end,
  output logic      o_mosi,
  output logic      o_latch
);
  logic [2:0] meta;  // First stage, read only by the second stage.
  logic [2:0] sync;  // Second stage, safe to decode.
  logic [2:0] prev;  // Delayed copy for edge finding.

  // Bit order is {mosi, latch, clock}; latch idles high so it resets high.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta <= 3'h2;
      sync <= 3'h2;
      prev <= 3'h2;
    end else begin
      meta <= {i_spi_mosi, i_spi_frame_latch, i_spi_clk};
      sync <= meta;
      prev <= sync;
    end
  end

  // Edges come from the second stage only, so all share one latency.
  assign o_sclk_rise   = sync[0] & ~prev[0];
  assign o_sclk_fall   = ~sync[0] & prev[0];
  assign o_frame_start = ~sync[1] & prev[1];
  assign o_frame_end   = sync[1] & ~prev[1];
  assign o_mosi        = sync[2];
  assign o_latch       = sync[1];
endmodule
`default_nettype wire

/* src/cpfd_slot_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpfd_defs.svh"
module cpfd_slot_mem (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_we_loc,
  input  wire logic        i_we_data,
  input  wire logic [2:0]  i_wr_idx,
  input  wire logic [9:0]  i_loc,
  input  wire logic [27:0] i_data,
  input  wire logic [2:0]  i_rd_idx,
  output logic      [9:0]  o_rd_loc,
  output logic      [27:0] o_rd_data
);
  logic [9:0]  loc_mem  [0:`CPFD_SLOT_LAST];  // Target location per slot.
  logic [27:0] data_mem [0:`CPFD_SLOT_LAST];  // Coefficient value per slot.
  wire         wr_ok = i_wr_idx < `CPFD_SLOT_COUNT;  // Guards the three spare codes.
  wire         rd_ok = i_rd_idx < `CPFD_SLOT_COUNT;

  // Location and data halves are written by separate words.
  always_ff @(posedge i_ref_clk) begin
    if (i_we_loc && wr_ok) begin
      loc_mem[i_wr_idx] <= i_loc;
    end
    if (i_we_data && wr_ok) begin
      data_mem[i_wr_idx] <= i_data;
    end
  end

  // Read data leaves through a register, one cycle after the index.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !rd_ok) begin
      o_rd_loc  <= 10'h000;
      o_rd_data <= 28'h000_0000;
    end else begin
      o_rd_loc  <= loc_mem[i_rd_idx];
      o_rd_data <= data_mem[i_rd_idx];
    end
  end
endmodule
`default_nettype wire

/* src/cpfd_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpfd_defs.svh"
module cpfd_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_spi_clk,
  input  wire logic        i_spi_frame_latch,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe,
  output logic             o_wr_valid,
  output logic      [11:0] o_wr_loc,
  output logic      [39:0] o_wr_data,
  output logic             o_rd_req,
  output logic      [11:0] o_rd_loc,
  input  wire logic [39:0] i_rd_data,
  output logic      [10:0] o_probe_step_index,
  output logic      [1:0]  o_probe_source_select,
  input  wire logic        i_coef_idle,
  output logic             o_sl_valid,
  output logic      [9:0]  o_sl_loc,
  output logic      [27:0] o_sl_data
);
  // Classify a location into its layout region.
  function automatic cpfd_pkg::cpfd_region_t region(input logic [11:0] loc);
    if (loc <= `CPFD_LOC_COEF_LAST) begin
      region = cpfd_pkg::RG_COEF;
    end else if (loc <= `CPFD_LOC_PROG_LAST) begin
      region = cpfd_pkg::RG_PROG;
    end else if (loc <= `CPFD_LOC_IFACE_LAST) begin
      region = cpfd_pkg::RG_IFACE;
    end else if (loc >= `CPFD_LOC_SLDATA_FIRST && loc < `CPFD_LOC_SLADDR_FIRST) begin
      region = cpfd_pkg::RG_SLDATA;
    end else if (loc >= `CPFD_LOC_SLADDR_FIRST && loc < `CPFD_LOC_CAPT_FIRST) begin
      region = cpfd_pkg::RG_SLADDR;
    end else if (loc >= `CPFD_LOC_CAPT_FIRST && loc <= `CPFD_LOC_CAPT_LAST) begin
      region = cpfd_pkg::RG_CAPT;
    end else if (loc >= `CPFD_LOC_BYTE1_FIRST && loc <= `CPFD_LOC_BYTE1_LAST) begin
      region = cpfd_pkg::RG_BYTE1;
    end else begin
      region = cpfd_pkg::RG_REG;
    end
  endfunction

  // Data bytes that follow for one word of a region.
  function automatic logic [2:0] word_len(input cpfd_pkg::cpfd_region_t rg, input logic rd);
    case (rg)
      cpfd_pkg::RG_COEF:   word_len = `CPFD_LEN_COEF;
      cpfd_pkg::RG_PROG:   word_len = `CPFD_LEN_PROG;
      cpfd_pkg::RG_IFACE:  word_len = `CPFD_LEN_COEF;
      cpfd_pkg::RG_SLDATA: word_len = `CPFD_LEN_SLDATA;
      cpfd_pkg::RG_CAPT:   word_len = rd ? `CPFD_LEN_CAPT_RD : `CPFD_LEN_CAPT_WR;
      cpfd_pkg::RG_BYTE1:  word_len = `CPFD_LEN_BYTE1;
      default:             word_len = `CPFD_LEN_REG;
    endcase
  endfunction

  // Mask of the significant bits of a word; padding above falls outside.
  function automatic logic [39:0] sig_mask(input cpfd_pkg::cpfd_region_t rg, input logic rd);
    logic [5:0] bits;
    bits = {word_len(rg, rd), 3'h0};
    case (rg)
      cpfd_pkg::RG_COEF, cpfd_pkg::RG_IFACE, cpfd_pkg::RG_SLDATA: bits = `CPFD_BITS_COEF;
      cpfd_pkg::RG_PROG:   bits = `CPFD_BITS_PROG;
      cpfd_pkg::RG_SLADDR: bits = `CPFD_BITS_SLADDR;
      cpfd_pkg::RG_CAPT:   bits = rd ? `CPFD_BITS_CAPT_RD : `CPFD_BITS_CAPT_WR;
      default:             bits = bits;
    endcase
    // A full 40-bit width wraps the shift to zero, which leaves all ones.
    sig_mask = (40'h00_0000_0001 << bits) - 40'h00_0000_0001;
  endfunction

  // Synchronised link signals.
  logic s_rise;
  logic s_fall;
  logic s_start;
  logic s_end;
  logic s_mosi;
  logic s_latch;

  cpfd_link_sync u_sync (
    .i_ref_clk         (i_ref_clk),
    .i_rst             (i_rst),
    .i_spi_clk         (i_spi_clk),
    .i_spi_frame_latch (i_spi_frame_latch),
    .i_spi_mosi        (i_spi_mosi),
    .o_sclk_rise       (s_rise),
    .o_sclk_fall       (s_fall),
    .o_frame_start     (s_start),
    .o_frame_end       (s_end),
    .o_mosi            (s_mosi),
    .o_latch           (s_latch)
  );

  cpfd_pkg::cpfd_state_t state;  // Decoder state.
  logic [6:0]  dev_addr;         // Own device select field.
  logic [2:0]  bit_cnt;          // Bits of the byte in progress.
  logic [7:0]  rx_byte;          // Byte shift register.
  logic        byte_strobe;      // One cycle after a byte completes.
  logic [1:0]  hdr_idx;          // Header byte number.
  logic        dir_rd;           // Direction bit of this frame.
  logic [11:0] cur_loc;          // Location of the word in progress.
  logic [2:0]  data_cnt;         // Data bytes so far in this word.
  logic [39:0] acc;              // Received data bytes, right aligned.
  logic        tx_load;          // Read data is captured this cycle.
  logic [39:0] tx_shift;         // Outgoing read bits, MSB first.
  logic [15:0] word_count;       // Words moved since reset.
  logic        sl_pending;       // Software asked for a slot copy.
  logic        sl_busy;          // Slot copy in progress.
  logic [2:0]  sl_idx;           // Slot being copied.

  // Per-word decode of the current location.
  wire cpfd_pkg::cpfd_region_t cur_rg = region(cur_loc);
  wire [2:0]  cur_len   = word_len(cur_rg, dir_rd);
  wire [39:0] cur_mask  = sig_mask(cur_rg, dir_rd);
  wire [7:0]  next_byte = {rx_byte[6:0], s_mosi};
  wire [39:0] next_acc  = {acc[31:0], rx_byte};
  wire        in_frame  = ~s_latch;
  wire        in_hdr    = byte_strobe && state == cpfd_pkg::ST_HDR;
  wire        in_data   = byte_strobe && state == cpfd_pkg::ST_DATA;
  wire        hdr_last  = in_hdr && hdr_idx == 2'h2;
  wire        word_end  = in_data && data_cnt == cur_len - 3'h1;
  wire        wr_word   = word_end && !dir_rd;
  wire        rd_fire   = (hdr_last && dir_rd) || (word_end && dir_rd);
  wire [11:0] next_loc  = hdr_last ? {cur_loc[11:8], rx_byte} : cur_loc + 12'h001;
  wire [5:0]  tx_amt    = {`CPFD_LEN_PROG - cur_len, 3'h0};
  wire [2:0]  sl_wr_idx = word_end && cur_rg == cpfd_pkg::RG_SLADDR ?
                          3'(cur_loc - `CPFD_LOC_SLADDR_FIRST) : 3'(cur_loc - `CPFD_LOC_SLDATA_FIRST);

  // Byte assembly: MOSI is taken on each rising link clock edge.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || s_start) begin
      bit_cnt <= 3'h0;
      rx_byte <= 8'h00;
    end else if (s_rise && in_frame) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_byte <= next_byte;
    end
  end

  // The strobe trails the eighth edge by one cycle so rx_byte is whole.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      byte_strobe <= 1'b0;
    end else begin
      byte_strobe <= s_rise && in_frame && bit_cnt == 3'h7;
    end
  end

  // Frame sequencer. A frame end always wins, even mid-word.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || s_end) begin
      state <= cpfd_pkg::ST_IDLE;
    end else if (s_start) begin
      state <= cpfd_pkg::ST_HDR;
    end else if (byte_strobe) begin
      case (state)
        cpfd_pkg::ST_HDR: begin
          if (hdr_idx == 2'h0 && rx_byte[7:1] != dev_addr) begin
            state <= cpfd_pkg::ST_SKIP;
          end else if (hdr_idx == 2'h2) begin
            state <= cpfd_pkg::ST_DATA;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // Header fields: select and direction, then location MSB first.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || s_start) begin
      hdr_idx <= 2'h0;
    end else if (in_hdr) begin
      hdr_idx <= hdr_idx + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dir_rd  <= 1'b0;
      cur_loc <= 12'h000;
    end else if (in_hdr && hdr_idx == 2'h0) begin
      dir_rd <= rx_byte[0];
    end else if (in_hdr && hdr_idx == 2'h1) begin
      cur_loc[11:8] <= rx_byte[3:0];
    end else if (hdr_last || word_end) begin
      cur_loc <= next_loc;
    end
  end

  // Data byte count and accumulator; padding bits are shifted in and masked later.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || hdr_last) begin
      data_cnt <= 3'h0;
    end else if (in_data) begin
      data_cnt <= word_end ? 3'h0 : data_cnt + 3'h1;
      acc      <= next_acc;
    end
  end

  // Write word out; bits above the significant width are dropped.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_wr_valid <= 1'b0;
      o_wr_loc   <= 12'h000;
      o_wr_data  <= 40'h00_0000_0000;
    end else begin
      o_wr_valid <= wr_word;
      if (wr_word) begin
        o_wr_loc  <= cur_loc;
        o_wr_data <= next_acc & cur_mask;
      end
    end
  end

  // Probe setup: step index in bits [12:2], source in [1:0] of the word.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_probe_step_index    <= 11'h000;
      o_probe_source_select <= 2'h0;
    end else if (wr_word && cur_rg == cpfd_pkg::RG_CAPT) begin
      o_probe_step_index    <= next_acc[12:2];
      o_probe_source_select <= next_acc[1:0];
    end
  end

  // Read request per word; the answer is taken on the following cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_req <= 1'b0;
      o_rd_loc <= 12'h000;
      tx_load  <= 1'b0;
    end else begin
      o_rd_req <= rd_fire;
      tx_load  <= o_rd_req;
      if (rd_fire) begin
        o_rd_loc <= next_loc;
      end
    end
  end

  // Read bits change on falling link clock edges so the host can take them on rising ones.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_shift   <= 40'h00_0000_0000;
      o_spi_miso <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= (i_rd_data & cur_mask) << tx_amt;
    end else if (s_fall && state == cpfd_pkg::ST_DATA && dir_rd) begin
      o_spi_miso <= tx_shift[39];
      tx_shift   <= {tx_shift[38:0], 1'b0};
    end
  end

  // MISO is driven only in the data phase of a read addressed to us.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_spi_miso_oe <= 1'b0;
    end else begin
      o_spi_miso_oe <= state == cpfd_pkg::ST_DATA && dir_rd && !s_end;
    end
  end

  // Deferred slots take location or data words as they arrive.
  cpfd_slot_mem u_slots (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we_loc  (wr_word && cur_rg == cpfd_pkg::RG_SLADDR),
    .i_we_data (wr_word && cur_rg == cpfd_pkg::RG_SLDATA),
    .i_wr_idx  (sl_wr_idx),
    .i_loc     (next_acc[9:0]),
    .i_data    (next_acc[27:0]),
    .i_rd_idx  (sl_idx),
    .o_rd_loc  (o_sl_loc),
    .o_rd_data (o_sl_data)
  );

  // Slot copy walks all five slots, pausing while coefficient memory is busy.
  wire sl_start = sl_pending && !sl_busy && i_coef_idle;
  wire sl_step  = sl_busy && i_coef_idle;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sl_busy <= 1'b0;
      sl_idx  <= 3'h0;
    end else if (sl_start) begin
      sl_busy <= 1'b1;
      sl_idx  <= 3'h0;
    end else if (sl_step) begin
      sl_busy <= sl_idx != `CPFD_SLOT_LAST;
      sl_idx  <= sl_idx + 3'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sl_valid <= 1'b0;
    end else begin
      o_sl_valid <= sl_step;
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with an error.
  wire apb_acc   = i_psel && i_penable;
  wire apb_setup = i_psel && !i_penable;
  wire sel_ctrl  = i_paddr == `CPFD_OFS_CTRL;
  wire sel_stat  = i_paddr == `CPFD_OFS_STATUS;
  wire sel_cnt   = i_paddr == `CPFD_OFS_COUNT;
  wire ctrl_wr   = apb_acc && i_pwrite && sel_ctrl;
  wire [31:0] rd_mux = sel_ctrl ? {24'h00_0000, 1'b0, dev_addr} :
                       sel_stat ? {14'h0000, s_latch == 1'b0, sl_busy, sl_pending, dir_rd, 2'(state), cur_loc} :
                       sel_cnt  ? {16'h0000, word_count} : 32'h0000_0000;

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !(sel_ctrl || sel_stat || sel_cnt);

  // Read data is registered in the setup cycle, ready for the access cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      o_prdata <= rd_mux;
    end
  end

  // Software writes steer the select field and request slot copies; a request wins over the start clear.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dev_addr   <= `CPFD_DEV_ADDR_RST;
      sl_pending <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        dev_addr <= i_pwdata[6:0];
      end
      sl_pending <= (ctrl_wr && i_pwdata[`CPFD_CTRL_COMMIT_BIT]) || (sl_pending && !sl_start);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      word_count <= 16'h0000;
    end else if (word_end) begin
      word_count <= word_count + 16'h0001;
    end
  end

  AST_SKIP_SILENT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == cpfd_pkg::ST_SKIP |=> !o_wr_valid && !o_rd_req && !o_spi_miso_oe) else $error("skipped frame acted");
  AST_COEF_PAD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wr_valid && o_wr_loc <= `CPFD_LOC_COEF_LAST |-> o_wr_data[39:28] == 12'h000) else $error("coef pad set");
  AST_BURST_INC: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wr_valid |-> cur_loc == o_wr_loc + 12'h001) else $error("location not advanced");
  AST_PROG_LEN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    word_end && cur_loc > `CPFD_LOC_COEF_LAST && cur_loc <= `CPFD_LOC_PROG_LAST |-> data_cnt == 3'h4)
    else $error("instruction word length wrong");
  AST_HDR_THREE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $changed(state) && state == cpfd_pkg::ST_DATA |-> $past(hdr_idx) == 2'h2) else $error("header not three bytes");
  AST_PROBE_FIELDS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wr_valid && region(o_wr_loc) == cpfd_pkg::RG_CAPT |-> o_probe_step_index == o_wr_data[12:2])
    else $error("probe index mismatch");
  AST_RD_ZERO_LOW: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tx_load && cur_rg == cpfd_pkg::RG_CAPT && dir_rd |=> tx_shift[15:0] == 16'h0000) else $error("probe read misaligned");
  AST_SL_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_sl_valid |-> $past(i_coef_idle) && $past(sl_busy)) else $error("slot copied while busy");
  AST_END_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_end |=> state == cpfd_pkg::ST_IDLE ##1 !o_spi_miso_oe) else $error("frame end not honoured");
endmodule
`default_nettype wire

/* dv/cpfd_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the serial link, mode 0; the clock stands low between frames.
module cpfd_spi_host (
  output logic      o_sclk,
  output logic      o_latch,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // The link starts idle with the frame line high.
  initial begin
    o_sclk = 1'b0;
    o_latch = 1'b1;
    o_mosi = 1'b0;
  end
  // Sends n bytes, right aligned in tx, first byte first, and shifts in what comes back.
  task automatic frame(input logic [127:0] tx, input int n, output logic [127:0] rx);
    rx = '0;
    // Link pins move on reference clock edges, so they change by non-blocking update to avoid a race.
    o_latch <= 1'b0;
    #600;
    for (int i = 8 * n - 1; i >= 0; i--) begin
      o_mosi <= tx[i];
      #200 o_sclk <= 1'b1;
      #190 rx = {rx[126:0], i_miso};
      #10 o_sclk <= 1'b0;
    end
    #600 o_latch <= 1'b1;
    // A released data line must not keep showing the last bit.
    o_mosi <= ~o_mosi;
    #1200;
  endtask
endmodule
`default_nettype wire

/* dv/tb_cpfd_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_cpfd_top;
  logic        clk, rst, psel, pen, pwr, err, idle;
  logic [11:0] paddr, rd_loc, wr_loc;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] rd_data, wr_data;
  logic [127:0] rx;
  logic [51:0] wq[$];
  logic [37:0] sq[$];
  wire         pready, pslverr, sclk, latch, mosi, miso, miso_oe, wr_v, rd_req, sl_v;
  wire  [10:0] pidx;
  wire  [1:0]  psrc;
  wire  [9:0]  sl_loc;
  wire  [27:0] sl_data;
  int          fail_count = 0;
  int          checks = 0;
  cpfd_top u_cpfd_top (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_spi_clk(sclk), .i_spi_frame_latch(latch), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .o_spi_miso_oe(miso_oe), .o_wr_valid(wr_v), .o_wr_loc(wr_loc), .o_wr_data(wr_data), .o_rd_req(rd_req),
    .o_rd_loc(rd_loc), .i_rd_data(rd_data), .o_probe_step_index(pidx), .o_probe_source_select(psrc),
    .i_coef_idle(idle), .o_sl_valid(sl_v), .o_sl_loc(sl_loc), .o_sl_data(sl_data));
  cpfd_spi_host u_cpfd_spi_host (.o_sclk(sclk), .o_latch(latch), .o_mosi(mosi), .i_miso(miso_oe ? miso : 1'bz));
  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Records every written word and slot copy, and answers reads one cycle after the request.
  // The answer carries set bits above the 24-bit probe readback field, which the block must drop.
  always @(posedge clk) begin
    if (wr_v === 1'b1) wq.push_back({wr_loc, wr_data});
    if (sl_v === 1'b1) sq.push_back({sl_loc, sl_data});
    rd_data <= {16'hFFFF, 12'h000, rd_loc};
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Prints the verdict and stops.
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Resets, then works through the frame scenarios.
  initial begin
    {rst, psel, pen, pwr, idle} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("select", rd, 32'h0000_002A);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped", {err, rd}, 33'h1_0000_0000);
    // Burst across the coefficient and instruction boundary, pad bits set on purpose.
    u_cpfd_spi_host.frame(96'h5403_FFF1_2345_67AB_CDEF_0123, 12, rx);
    chk("coef", wq[0], {12'h3FF, 40'h00_0123_4567});
    chk("prog", wq[1], {12'h400, 40'hAB_CDEF_0123});
    wq.delete();
    // A frame for another device must leave nothing behind.
    u_cpfd_spi_host.frame(56'hAC_0001_0080_0000, 7, rx);
    chk("foreign", wq.size(), 0);
    u_cpfd_spi_host.frame(40'h54_081A_1696, 5, rx);
    chk("probe", {pidx, psrc}, {11'h5A5, 2'h2});
    u_cpfd_spi_host.frame(48'h5508_1A00_0000, 6, rx);
    chk("probe rd", rx[23:0], 24'h00_081A);
    wq.delete();
    // Two-byte registers run into a one-byte register inside one burst.
    u_cpfd_spi_host.frame(64'h5408_1C12_3456_789A, 8, rx);
    chk("reg a", wq[0], {12'h81C, 40'h00_0000_1234});
    chk("reg b", wq[1], {12'h81D, 40'h00_0000_5678});
    chk("byte reg", wq[2], {12'h81E, 40'h00_0000_009A});
    u_cpfd_spi_host.frame(40'h54_0815_FE77, 5, rx);
    u_cpfd_spi_host.frame(64'h5408_10FF_F987_6543, 8, rx);
    // No copy may start while the coefficient memory is busy.
    apb(1'b1, 12'h000, 32'h0000_012A);
    repeat (20) @(posedge clk);
    chk("held", sq.size(), 0);
    idle <= 1'b1;
    for (int k = 0; k < 200 && sq.size() < 5; k++) @(posedge clk);
    chk("copies", sq.size(), 5);
    chk("slot0", sq[0], {10'h277, 28'h987_6543});
    // Nine whole words moved so far; the foreign frame adds none.
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("count", rd, 32'h0000_0009);
    // Idle, no copy pending, location one past the last slot data word.
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status", rd, 32'h0000_0811);
    end_of_test();
  end
  // Cuts a hang short after about 40000 cycles.
  initial begin
    #2000000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
